// >>> verilog/cam_pkg.sv
package cam_pkg;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MEMDATA = 8'h04;
  localparam logic [7:0] OFF_RESULT_LO = 8'h08;
  localparam logic [7:0] OFF_RESULT_HI = 8'h0c;
  localparam logic [7:0] OFF_FLAGS = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [1:0] WREG_REGION = 2'h1;

  // ****************************************************************
  // Control word fields
  // ****************************************************************
  localparam int CTL_OP_LSB = 0;
  localparam int CTL_BYTE = 4;
  localparam int CTL_A_MEM = 5;
  localparam int CTL_B_MEM = 6;
  localparam int CTL_DST_MEM = 7;
  localparam int CTL_RA_LSB = 8;
  localparam int CTL_RB_LSB = 12;
  localparam int CTL_RD_LSB = 16;
  localparam int CTL_MUL_LSB = 20;
  localparam int CTL_DIV_SIGNED = 23;
  localparam int CTL_DIV_LONG = 24;
  localparam int CTL_HOLD = 26;
  localparam int CTL_LIT_LSB = 27;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // ****************************************************************
  // Operation and multiply mode codes
  // ****************************************************************
  localparam logic [3:0] OP_ADD = 4'h0;
  localparam logic [3:0] OP_SUB = 4'h1;
  localparam logic [3:0] OP_AND = 4'h2;
  localparam logic [3:0] OP_IOR = 4'h3;
  localparam logic [3:0] OP_XOR = 4'h4;
  localparam logic [3:0] OP_SHA = 4'h5;
  localparam logic [3:0] OP_SHL = 4'h6;
  localparam logic [3:0] OP_MUL = 4'h7;
  localparam logic [3:0] OP_DIV = 4'h8;

  localparam logic [2:0] MUL_SS = 3'h0;
  localparam logic [2:0] MUL_UU = 3'h1;
  localparam logic [2:0] MUL_US = 3'h2;
  localparam logic [2:0] MUL_SLIT = 3'h3;
  localparam logic [2:0] MUL_ULIT = 3'h4;
  localparam logic [2:0] MUL_BYTE = 3'h5;

  // ****************************************************************
  // Flag bit positions in the cpu_flags_word
  // ****************************************************************
  localparam int FLG_BORROW_OUT = 0;
  localparam int FLG_NULL = 1;
  localparam int FLG_WRAP = 2;
  localparam int FLG_MSB = 3;
  localparam int FLG_HALF = 8;
  localparam logic [15:0] FLAGS_RESET = 16'h0000;
  localparam logic [15:0] FLAGS_MASK = 16'h010f;

  // ****************************************************************
  // Divider timing
  // ****************************************************************
  localparam logic [4:0] DIV_ITER_LAST = 5'h0f;
  localparam int DIV_TOTAL_CYCLES = 19;

endpackage

// >>> verilog/cam_shifter.sv
`timescale 1ns/1ns
module cam_shifter (
  input wire logic [15:0] operand,
  input wire logic [5:0] count,
  input wire logic arith,
  output logic [15:0] result
);

  // ****************************************************************
  // Single-cycle barrel shift with a signed count
  // ****************************************************************
  wire logic go_left;
  wire logic [5:0] mag_raw;
  wire logic [4:0] mag;
  wire logic [31:0] ext_op;
  wire logic [31:0] right_val;
  wire logic [31:0] left_val;

  // Positive count goes right, negative left; counts past 16 clamp to 16
  assign go_left = count[5];
  assign mag_raw = go_left ? 6'(-count) : count;
  assign mag = (mag_raw > 6'h10) ? 5'h10 : mag_raw[4:0];
  assign ext_op = {{16{arith & operand[15]}}, operand};
  assign right_val = ext_op >> mag;
  assign left_val = {16'h0000, operand} << mag;
  // A zero count passes the operand through either path unchanged
  assign result = go_left ? left_val[15:0] : right_val[15:0];

endmodule

// >>> verilog/cam_divider.sv
`timescale 1ns/1ns
module cam_divider (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start,
  input wire logic hold,
  input wire logic is_signed,
  input wire logic is_long,
  input wire logic [31:0] dividend,
  input wire logic [15:0] divisor,
  output logic busy,
  output logic done,
  output logic [15:0] quot,
  output logic [15:0] rem
);

  // ****************************************************************
  // Iterative restoring divider, one quotient bit per cycle
  // ****************************************************************
  typedef enum logic [1:0] {DV_IDLE, DV_PREP, DV_ITER, DV_FIX} cam_dv_state_t;

  cam_dv_state_t state;
  logic [31:0] num;
  logic [15:0] den;
  logic [15:0] part;
  logic [15:0] qacc;
  logic [4:0] cnt;
  logic sgn;
  logic neg_q;
  logic neg_r;

  wire logic [31:0] abs_num;
  wire logic [15:0] abs_den;
  wire logic [17:0] trial;
  wire logic ge;
  wire logic [31:0] ext_div;

  // Short dividends are widened so both sizes run the same 16 steps
  assign ext_div = is_long ? dividend : {{16{is_signed & dividend[15]}}, dividend[15:0]};
  assign abs_num = (sgn & num[31]) ? 32'(-num) : num;
  assign abs_den = (sgn & den[15]) ? 16'(-den) : den;
  assign trial = {1'b0, part, qacc[15]} - {2'b00, den};
  assign ge = ~trial[17];
  assign busy = (state != DV_IDLE);

  // Sequencer; hold freezes all partial state so an interrupt loses nothing
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= DV_IDLE;
      num <= 32'h0000_0000;
      den <= 16'h0000;
      part <= 16'h0000;
      qacc <= 16'h0000;
      cnt <= 5'h00;
      sgn <= 1'b0;
      neg_q <= 1'b0;
      neg_r <= 1'b0;
      done <= 1'b0;
      quot <= 16'h0000;
      rem <= 16'h0000;
    end
    else
    begin
      done <= 1'b0;
      if (!hold)
      begin
        unique case (state)
          DV_IDLE:
          begin
            if (start)
            begin
              num <= ext_div;
              den <= divisor;
              sgn <= is_signed;
              state <= DV_PREP;
            end
          end
          DV_PREP:
          begin
            neg_r <= sgn & num[31];
            neg_q <= sgn & (num[31] ^ den[15]);
            den <= abs_den;
            part <= abs_num[31:16];
            qacc <= abs_num[15:0];
            cnt <= 5'h00;
            state <= DV_ITER;
          end
          DV_ITER:
          begin
            // Remaining dividend bits shift out of qacc as quotient bits shift in
            part <= ge ? trial[15:0] : {part[14:0], qacc[15]};
            qacc <= {qacc[14:0], ge};
            cnt <= 5'(cnt + 5'h01);
            if (cnt == cam_pkg::DIV_ITER_LAST)
            begin
              state <= DV_FIX;
            end
          end
          DV_FIX:
          begin
            quot <= neg_q ? 16'(-qacc) : qacc;
            rem <= neg_r ? 16'(-part) : part;
            done <= 1'b1;
            state <= DV_IDLE;
          end
        endcase
      end
    end
  end

endmodule

// >>> verilog/cam_alu_top.sv
`timescale 1ns/1ns
// Contract
// - 16-bit ALU doing add, subtract, shifts and logic, two's complement.
// - ALU updates borrow, null, msb, wrap and half-carry flags by operation.
// - On subtraction the borrow and half-carry bits flag borrows, not carries.
// - Each operation but divide writes a byte or word to its destination, chosen per command; shifts always work on the whole word,
//   though a byte-mode shift here writes only the low byte of its word result to the destination.
// - Operands from working registers or memory; results to either place.
// - A 17x17 multiplier does unsigned, signed and mixed-sign products.
// - Multiply modes: SS, UU, US, by 5-bit literal, and byte by byte.
// - Divider does signed and unsigned 32/16 and 16/16 division.
// - Divide writes quotient to working register zero, remainder to one.
// - Divisor from any register; long dividend from even-aligned pair, odd high.
// - One quotient bit per cycle, so both divide sizes take equal time.
// - Shifter does arithmetic/logical right and left shifts up to 16 in one cycle.
// - Shift operand comes from a working register or a memory location.
// - Signed count: positive shifts right, negative left, zero leaves operand alone.
// - A whole divide takes 19 cycles.
// - Divider may be paused in any cycle and keeps its partial state.
// - Word multiplies use 17-bit operands, the extra bit a sign or zero extension.
module cam_alu_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [15:0] wreg [16];
  logic [31:0] ctrl;
  logic [15:0] memdata;
  logic [15:0] result_lo;
  logic [15:0] result_hi;
  logic [15:0] cpu_flags_word;
  logic exec;
  logic wr_pend;
  logic [7:0] wr_addr;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire logic addr_valid;
  wire logic wr_fire;
  wire logic wr_ctrl;
  wire logic wr_mem;
  wire logic wr_flags;
  wire logic wr_wreg;
  wire logic [3:0] wr_idx;
  wire logic [3:0] rd_idx;
  wire logic rd_is_wreg;
  wire logic [31:0] rd_val;
  wire logic div_busy;
  wire logic div_done;
  wire logic [15:0] div_quot;
  wire logic [15:0] div_rem;

  // Zero-wait slave: address phase captured whenever the bus is ready
  assign addr_valid = hsel & htrans[1] & hready;
  assign wr_fire = wr_pend;
  assign wr_ctrl = wr_fire & (wr_addr == cam_pkg::OFF_CTRL);
  assign wr_mem = wr_fire & (wr_addr == cam_pkg::OFF_MEMDATA);
  assign wr_flags = wr_fire & (wr_addr == cam_pkg::OFF_FLAGS);
  assign wr_wreg = wr_fire & (wr_addr[7:6] == cam_pkg::WREG_REGION);
  assign wr_idx = wr_addr[5:2];
  assign rd_idx = haddr[5:2];
  assign rd_is_wreg = (haddr[7:6] == cam_pkg::WREG_REGION) & (haddr[31:8] == 24'h00_0000);

  // Read mux; unmapped words read zero
  assign rd_val = rd_is_wreg ? {16'h0000, wreg[rd_idx]} :
                  (haddr == {24'h00_0000, cam_pkg::OFF_CTRL}) ? ctrl :
                  (haddr == {24'h00_0000, cam_pkg::OFF_MEMDATA}) ? {16'h0000, memdata} :
                  (haddr == {24'h00_0000, cam_pkg::OFF_RESULT_LO}) ? {16'h0000, result_lo} :
                  (haddr == {24'h00_0000, cam_pkg::OFF_RESULT_HI}) ? {16'h0000, result_hi} :
                  (haddr == {24'h00_0000, cam_pkg::OFF_FLAGS}) ? {16'h0000, cpu_flags_word} :
                  (haddr == {24'h00_0000, cam_pkg::OFF_STATUS}) ? {31'h0000_0000, div_busy} :
                  32'h0000_0000;

  // ****************************************************************
  // Command fields
  // ****************************************************************
  wire logic [3:0] op;
  wire logic byte_mode;
  wire logic [3:0] ra;
  wire logic [3:0] rb;
  wire logic [3:0] rd;
  wire logic [2:0] mul_mode;
  wire logic [4:0] lit5;
  wire logic [15:0] opa;
  wire logic [15:0] opb;

  assign op = ctrl[cam_pkg::CTL_OP_LSB +: 4];
  assign byte_mode = ctrl[cam_pkg::CTL_BYTE];
  assign ra = ctrl[cam_pkg::CTL_RA_LSB +: 4];
  assign rb = ctrl[cam_pkg::CTL_RB_LSB +: 4];
  assign rd = ctrl[cam_pkg::CTL_RD_LSB +: 4];
  assign mul_mode = ctrl[cam_pkg::CTL_MUL_LSB +: 3];
  assign lit5 = ctrl[cam_pkg::CTL_LIT_LSB +: 5];
  // Operand source follows the addressing choice in the command
  assign opa = ctrl[cam_pkg::CTL_A_MEM] ? memdata : wreg[ra];
  assign opb = ctrl[cam_pkg::CTL_B_MEM] ? memdata : wreg[rb];

  // ****************************************************************
  // Add and subtract with flags
  // ****************************************************************
  wire logic is_sub;
  wire logic [16:0] sum_w;
  wire logic [8:0] sum_b;
  wire logic [8:0] half_w;
  wire logic [4:0] half_b;
  wire logic [15:0] arith_res;
  wire logic a_msb;
  wire logic b_msb;
  wire logic r_msb;
  wire logic carry_bit;
  wire logic half_bit;
  wire logic wrap_bit;

  assign is_sub = (op == cam_pkg::OP_SUB);
  // Subtraction keeps the top bit as an active-high borrow
  assign sum_w = is_sub ? 17'({1'b0, opa} - {1'b0, opb}) : 17'({1'b0, opa} + {1'b0, opb});
  assign sum_b = is_sub ? 9'({1'b0, opa[7:0]} - {1'b0, opb[7:0]}) : 9'({1'b0, opa[7:0]} + {1'b0, opb[7:0]});
  assign half_w = is_sub ? 9'({1'b0, opa[7:0]} - {1'b0, opb[7:0]}) : 9'({1'b0, opa[7:0]} + {1'b0, opb[7:0]});
  assign half_b = is_sub ? 5'({1'b0, opa[3:0]} - {1'b0, opb[3:0]}) : 5'({1'b0, opa[3:0]} + {1'b0, opb[3:0]});
  assign arith_res = byte_mode ? {8'h00, sum_b[7:0]} : sum_w[15:0];
  // Width picks which bits feed each flag
  assign a_msb = byte_mode ? opa[7] : opa[15];
  assign b_msb = byte_mode ? opb[7] : opb[15];
  assign r_msb = byte_mode ? sum_b[7] : sum_w[15];
  assign carry_bit = byte_mode ? sum_b[8] : sum_w[16];
  // Digit carry: 4th low bit in byte mode, 8th in word mode
  assign half_bit = byte_mode ? half_b[4] : half_w[8];
  // Sign flips when operands agree in sign for add, differ for subtract
  assign wrap_bit = (is_sub ? (a_msb ^ b_msb) : ~(a_msb ^ b_msb)) & (r_msb ^ a_msb);

  // ****************************************************************
  // Logic, shift and multiply
  // ****************************************************************
  wire logic [15:0] logic_full;
  wire logic [15:0] logic_res;
  wire logic [15:0] shift_res;
  wire logic a_ext;
  wire logic b_ext;
  wire logic [16:0] mul_a;
  wire logic [16:0] mul_b;
  wire logic [33:0] product;

  assign logic_full = (op == cam_pkg::OP_AND) ? (opa & opb) :
                      (op == cam_pkg::OP_IOR) ? (opa | opb) : (opa ^ opb);
  assign logic_res = byte_mode ? {8'h00, logic_full[7:0]} : logic_full;

  cam_shifter u_shift (
    .operand(opa),
    .count(opb[5:0]),
    .arith(op == cam_pkg::OP_SHA),
    .result(shift_res)
  );

  // The 17th bit is the sign for signed operands and zero otherwise
  assign a_ext = ((mul_mode == cam_pkg::MUL_SS) | (mul_mode == cam_pkg::MUL_SLIT)) & opa[15];
  assign b_ext = ((mul_mode == cam_pkg::MUL_SS) | (mul_mode == cam_pkg::MUL_US)) & opb[15];
  assign mul_a = (mul_mode == cam_pkg::MUL_BYTE) ? {9'h000, opa[7:0]} : {a_ext, opa};
  assign mul_b = (mul_mode == cam_pkg::MUL_BYTE) ? {9'h000, opb[7:0]} :
                 ((mul_mode == cam_pkg::MUL_SLIT) | (mul_mode == cam_pkg::MUL_ULIT)) ? {12'h000, lit5} :
                 {b_ext, opb};
  assign product = 34'($signed(mul_a) * $signed(mul_b));

  // ****************************************************************
  // Result selection and flag update
  // ****************************************************************
  wire logic [15:0] alu_res;
  wire logic [15:0] alu_chk;
  wire logic [15:0] next_flags;
  wire logic flag_arith;
  wire logic flag_zn;
  wire logic is_div;
  wire logic do_write;

  assign is_div = (op == cam_pkg::OP_DIV);
  assign alu_res = ((op == cam_pkg::OP_ADD) | is_sub) ? arith_res :
                   ((op == cam_pkg::OP_SHA) | (op == cam_pkg::OP_SHL)) ? shift_res :
                   (op == cam_pkg::OP_MUL) ? product[15:0] : logic_res;
  assign alu_chk = byte_mode ? {8'h00, alu_res[7:0]} : alu_res;
  assign flag_arith = (op == cam_pkg::OP_ADD) | is_sub;
  assign flag_zn = flag_arith | (op == cam_pkg::OP_AND) | (op == cam_pkg::OP_IOR) |
                   (op == cam_pkg::OP_XOR) | (op == cam_pkg::OP_SHA) | (op == cam_pkg::OP_SHL);
  // Multiply and divide leave the flags alone
  assign next_flags = {7'h00,
                       flag_arith ? half_bit : cpu_flags_word[cam_pkg::FLG_HALF],
                       4'h0,
                       flag_zn ? (byte_mode ? alu_chk[7] : alu_chk[15]) : cpu_flags_word[cam_pkg::FLG_MSB],
                       flag_arith ? wrap_bit : cpu_flags_word[cam_pkg::FLG_WRAP],
                       flag_zn ? (alu_chk == 16'h0000) : cpu_flags_word[cam_pkg::FLG_NULL],
                       flag_arith ? carry_bit : cpu_flags_word[cam_pkg::FLG_BORROW_OUT]};
  assign do_write = exec & ~is_div;

  // ****************************************************************
  // Divider
  // ****************************************************************
  wire logic [31:0] div_dividend;

  // Long dividend from the even-aligned pair, odd register on top
  assign div_dividend = {wreg[{ra[3:1], 1'b1}], wreg[{ra[3:1], 1'b0}]};

  cam_divider u_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(exec & is_div),
    .hold(ctrl[cam_pkg::CTL_HOLD]),
    .is_signed(ctrl[cam_pkg::CTL_DIV_SIGNED]),
    .is_long(ctrl[cam_pkg::CTL_DIV_LONG]),
    .dividend(ctrl[cam_pkg::CTL_DIV_LONG] ? div_dividend : {16'h0000, wreg[ra]}),
    .divisor(wreg[rb]),
    .busy(div_busy),
    .done(div_done),
    .quot(div_quot),
    .rem(div_rem)
  );

  // ****************************************************************
  // Bus slave flops
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      wr_pend <= addr_valid & hwrite & (haddr[31:8] == 24'h00_0000);
      wr_addr <= haddr[7:0];
      if (addr_valid & ~hwrite)
      begin
        hrdata <= rd_val;
      end
    end
  end

  // Command latch; while dividing only the hold bit may change
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl <= cam_pkg::CTRL_RESET;
      exec <= 1'b0;
    end
    else
    begin
      exec <= wr_ctrl & ~div_busy & ~exec;
      if (wr_ctrl & ~div_busy & ~exec)
      begin
        ctrl <= hwdata;
      end
      else if (wr_ctrl)
      begin
        ctrl[cam_pkg::CTL_HOLD] <= hwdata[cam_pkg::CTL_HOLD];
      end
    end
  end

  // Memory operand, results and flags; engine updates win over bus writes
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      memdata <= 16'h0000;
      result_lo <= 16'h0000;
      result_hi <= 16'h0000;
      cpu_flags_word <= cam_pkg::FLAGS_RESET;
    end
    else
    begin
      if (do_write & ctrl[cam_pkg::CTL_DST_MEM])
      begin
        memdata <= byte_mode ? {memdata[15:8], alu_res[7:0]} : alu_res;
      end
      else if (wr_mem)
      begin
        memdata <= hwdata[15:0];
      end
      if (do_write)
      begin
        result_lo <= alu_res;
        result_hi <= (op == cam_pkg::OP_MUL) ? product[31:16] : 16'h0000;
        cpu_flags_word <= next_flags;
      end
      else if (div_done)
      begin
        result_lo <= div_quot;
        result_hi <= div_rem;
      end
      // A bus write to the flags must not be lost when a divide finishes in the same cycle
      if (wr_flags & ~do_write)
      begin
        cpu_flags_word <= hwdata[15:0] & cam_pkg::FLAGS_MASK;
      end
    end
  end

  // ****************************************************************
  // Working register array
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1)
    begin : g_wreg
      wire logic alu_hit;
      assign alu_hit = do_write & ~ctrl[cam_pkg::CTL_DST_MEM] & (rd == 4'(gi));

      // Byte results touch only the low byte of the destination
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          wreg[gi] <= 16'h0000;
        end
        else if (div_done & (gi < 2))
        begin
          wreg[gi] <= (gi == 0) ? div_quot : div_rem;
        end
        else if (alu_hit)
        begin
          wreg[gi] <= byte_mode ? {wreg[gi][15:8], alu_res[7:0]} : alu_res;
        end
        else if (wr_wreg & (wr_idx == 4'(gi)))
        begin
          wreg[gi] <= hwdata[15:0];
        end
      end
    end
  endgenerate

endmodule

// >>> testbench/cam_bus_master.sv
`timescale 1ns/1ns
module cam_bus_master (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  // ****
  // Single-word bus master
  // ****
  // Idle bus from time zero so reset sees no stray transfer
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // Address phase held until hready is seen high
  task automatic phase(input logic [31:0] a, input logic w);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    phase(a, 1'b1);
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
  endtask
  // Read data taken at the edge that ends the data phase
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    phase(a, 1'b0);
    do @(posedge hclk); while (hready !== 1'b1);
    d = hrdata;
  endtask
endmodule

// >>> testbench/cam_alu_checker.sv
`timescale 1ns/1ns
module cam_alu_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp
);
  // ****
  // Read address phase decode
  // ****
  wire logic rd = hsel && htrans[1] && hready && !hwrite;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_READY: assert property (hreadyout) else $error("wait state inserted");
  AST_OKAY: assert property (!hresp) else $error("error response");
  AST_HOLD: assert property (!$past(rd) |-> $stable(hrdata)) else $error("read data moved");
  AST_FLAGS: assert property (rd && haddr == 32'(cam_pkg::OFF_FLAGS) |=> (hrdata & 32'hfffffef0) == 32'h0)
    else $error("flag word has stray bits");
  AST_WREG: assert property (rd && haddr[31:6] == 26'h1 |=> hrdata[31:16] == 16'h0)
    else $error("working register wider than 16 bits");
  AST_MEM: assert property (rd && haddr == 32'(cam_pkg::OFF_MEMDATA) |=> hrdata[31:16] == 16'h0)
    else $error("memory word wider than 16 bits");
  AST_STAT: assert property (rd && haddr == 32'(cam_pkg::OFF_STATUS) |=> hrdata[31:1] == 31'h0)
    else $error("status has stray bits");
  AST_UNMAP: assert property (rd && haddr[31:8] != 24'h0 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  // Main scenarios reached
  cover property (rd && haddr == 32'(cam_pkg::OFF_STATUS) ##1 hrdata[0]);
  cover property (rd && haddr == 32'(cam_pkg::OFF_FLAGS) ##1 hrdata[8]);
  cover property (rd && haddr[31:6] == 26'h1);
endmodule
bind cam_alu_top cam_alu_checker chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

// >>> testbench/testbench.sv
`timescale 1ns/1ns
module testbench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;
  localparam logic [31:0] MD = 32'(cam_pkg::OFF_MEMDATA);
  localparam logic [31:0] RL = 32'(cam_pkg::OFF_RESULT_LO);
  localparam logic [31:0] RH = 32'(cam_pkg::OFF_RESULT_HI);
  localparam logic [31:0] FL = 32'(cam_pkg::OFF_FLAGS);
  localparam logic [31:0] ST = 32'(cam_pkg::OFF_STATUS);
  // ****
  // Clock, design and bus master
  // ****
  always #50 hclk = ~hclk;
  cam_alu_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp));
  cam_bus_master bus (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  // ****
  // Shared helpers
  // ****
  task automatic end_sim;
    $display("compares %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Single judge of every comparison; exact match so unknowns fail
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic see(input string nm, input logic [31:0] a, input logic [31:0] exp);
    bus.rd(a, rv);
    check(nm, rv, exp);
  endtask
  function automatic logic [31:0] wa(input int i);
    return 32'h40 + 32'(4 * i);
  endfunction
  // Idle cycle after each command so its result has landed before reading
  task automatic run(input logic [31:0] c);
    bus.wr(32'(cam_pkg::OFF_CTRL), c);
    @(posedge hclk);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_alu;
    bus.wr(MD, 32'h7fff);
    bus.wr(wa(2), 32'h1);
    run(32'h0000_20a0);
    see("add_mem", MD, 32'h8000);
    see("add_flags", FL, 32'h010c);
    bus.wr(wa(3), 32'h1200);
    bus.wr(wa(4), 32'h1);
    run(32'h0003_4311);
    see("sub_byte", wa(3), 32'h12ff);
    see("sub_flags", FL, 32'h0109);
  endtask
  // Signed count: sign fill, full shift by 16, left on negative, zero untouched
  task automatic t_shift;
    logic [31:0] op[6] = '{32'h5, 32'h6, 32'h6, 32'h5, 32'h6, 32'h5};
    logic [31:0] cn[6] = '{32'h1, 32'h1, 32'hfffc, 32'h0, 32'h10, 32'h10};
    logic [31:0] ex[6] = '{32'hc000, 32'h4000, 32'h0010, 32'h8001, 32'h0, 32'hffff};
    bus.wr(wa(5), 32'h8001);
    for (int i = 0; i < 6; i++)
    begin
      bus.wr(wa(6), cn[i]);
      run(32'h0007_6500 | op[i]);
      see("shift", wa(7), ex[i]);
    end
  endtask
  // Every multiply mode with -2 by -1 and literal 5
  task automatic t_mul;
    logic [31:0] ex[6] = '{32'h2, 32'hfffd0002, 32'hffff0002, 32'hfffffff6, 32'h4fff6, 32'hfd02};
    bus.wr(wa(8), 32'hfffe);
    bus.wr(wa(9), 32'hffff);
    for (int m = 0; m < 6; m++)
    begin
      run(32'h280a_9807 | (32'(m) << 20));
      see("mul_lo", RL, {16'h0, ex[m][15:0]});
      see("mul_hi", RH, {16'h0, ex[m][31:16]});
    end
  endtask
  // Signed long divide with a pause, then unsigned short divide timed
  task automatic t_div;
    logic [31:0] c[2] = '{32'h0180_b208, 32'h0000_bc08};
    logic [31:0] q[2] = '{32'hfff2, 32'he};
    logic [31:0] r[2] = '{32'hfffe, 32'h2};
    bus.wr(wa(2), 32'hff9c);
    bus.wr(wa(3), 32'hffff);
    bus.wr(wa(11), 32'h7);
    bus.wr(wa(12), 32'h64);
    for (int i = 0; i < 2; i++)
    begin
      run(c[i]);
      if (i == 0)
      begin
        run(c[i] | 32'h0400_0000);
        repeat (30) @(posedge hclk);
        see("div_held", ST, 32'h1);
        run(c[i]);
        repeat (20) @(posedge hclk);
      end
      else
      begin
        repeat (17) @(posedge hclk);
        see("div_busy", ST, 32'h1);
        see("div_done", ST, 32'h0);
      end
      see("quot", wa(0), q[i]);
      see("rem", wa(1), r[i]);
      see("res_lo", RL, q[i]);
      see("res_hi", RH, r[i]);
    end
  endtask
  // ****
  // Main sequence and hang guard
  // ****
  initial
  begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    see("flags_rst", FL, 32'h0);
    t_alu;
    t_shift;
    t_mul;
    t_div;
    see("unmapped", 32'h100, 32'h0);
    end_sim;
  end
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      end_sim;
    end
  end
endmodule
